// ===== verilog/bcr_defines.vh
// Constants for the converter control register bank: offsets, field positions, resets, codes.
// Assumes inclusion by bare name from the bank module; definitions only.
`ifndef BCR_DEFINES_VH
`define BCR_DEFINES_VH
`define BCR_IDX_ACTIVE   8'hB1
`define BCR_IDX_SLEEP    8'hB2
`define BCR_IDX_CMP      8'hB3
`define BCR_IDX_C1CTL    8'hB4
`define BCR_IDX_C1SEQ    8'hB5
`define BCR_IDX_KEY      8'hC0
`define BCR_IDX_IRQST    8'hC1
`define BCR_IDX_IRQMSK   8'hC2
`define BCR_IDX_STATUS   8'hC3
`define BCR_KEY_UNLOCK   16'h0097
`define BCR_RST_ACTIVE   16'h0001
`define BCR_RST_SLEEP    16'h0000
`define BCR_RST_CMP      16'h0025
`define BCR_RST_C1CTL    16'h000E
`define BCR_RST_C1SEQ    16'h0400
`define BCR_MSK_ACTIVE   16'h0001
`define BCR_MSK_SLEEP    16'h002D
`define BCR_MSK_CMP      16'h5077
`define BCR_MSK_C1CTL    16'hCC7F
`define BCR_MSK_C1SEQ    16'hFFC0
`define BCR_MSK_THR      16'h0077
`define BCR_B_CMP_ACT    14
`define BCR_B_CMP_HIB    12
`define BCR_F_OFFTHR     6:4
`define BCR_F_ONTHR      2:0
`define BCR_F_CAP        15:14
`define BCR_B_OVPOFF     11
`define BCR_B_FLOAT      10
`define BCR_F_VSEL       6:0
`define BCR_F_FACT       15:14
`define BCR_F_ENSLOT     13:10
`define BCR_F_SDSLOT     9:6
`define BCR_B_SLP1       0
`define BCR_B_SLP3       2
`define BCR_B_SLP4       3
`define BCR_B_SLP6       5
`define BCR_CAP_UNUSED   2'h2
`define BCR_VSEL_MAX     7'h66
`define BCR_FACT_IGNORE  2'h0
`define BCR_FACT_CONV    2'h1
`define BCR_SLOT_NONE    4'h0
`define BCR_SLOT_ACTIVE  4'hF
`define BCR_IRQ_SUPPLY   0
`define BCR_IRQ_FAULT    1
`endif

// ===== verilog/bcr_regs.v
// Converter control register bank with AXI4-Lite slave, interrupt status/mask and slot decode.
// Assumes one 40 MHz clock; comparator and fault inputs are asynchronous pins from analog.
`include "bcr_defines.vh"
module bcr_regs #(
   parameter AW = 12
) (
   input  wire          aclk,
   input  wire          aresetn,
   input  wire          sm_reset,
   input  wire [AW-1:0] s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output reg           s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output reg           s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [AW-1:0] s_axi_araddr,
   input  wire          s_axi_arvalid,
   output reg           s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   input  wire          supply_low,
   input  wire          conv1_fault,
   input  wire [3:0]    seq_slot,
   input  wire          seq_startup,
   input  wire          seq_shutdown,
   input  wire          enter_active,
   input  wire          enter_off,
   output reg           conv1_active_select,
   output reg  [3:0]    sleep_ldo_select,
   output reg           supply_check_hibernate_use,
   output reg  [2:0]    supply_turnoff_threshold,
   output reg  [2:0]    supply_turnon_threshold,
   output reg  [1:0]    conv1_output_cap_range,
   output reg           conv1_overvoltage_on,
   output reg           conv1_discharge_en,
   output reg  [6:0]    conv1_voltage_code,
   output reg           conv1_enable,
   output reg           conv1_shutdown_req,
   output reg           system_shutdown_req,
   output reg           irq
);
   reg [15:0] active_reg, sleep_reg, cmp_reg, c1ctl_reg, c1seq_reg;
   reg [1:0]  irqst_reg, irqmsk_reg;
   reg        unlock_reg;
   reg [2:0]  low_sync_reg, flt_sync_reg;
   reg        low_reg, flt_reg;
   reg        aw_hold_reg, w_hold_reg;
   reg [AW-1:0] awaddr_reg;
   reg [31:0] wdata_reg;
   reg [3:0]  wstrb_reg;
   wire [7:0] widx = awaddr_reg[9:2];
   wire [7:0] ridx = s_axi_araddr[9:2];
   wire       wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
   wire       low_rise = (low_sync_reg[2] == low_sync_reg[1]) && low_sync_reg[1] && !low_reg;
   wire       flt_rise = (flt_sync_reg[2] == flt_sync_reg[1]) && flt_sync_reg[1] && !flt_reg;
   wire [3:0] en_slot = c1seq_reg[`BCR_F_ENSLOT];
   wire [3:0] sd_slot = c1seq_reg[`BCR_F_SDSLOT];
   wire [1:0] fact = c1seq_reg[`BCR_F_FACT];

   // Merges byte lanes of a write under a field mask
   function [15:0] merge;
      input [15:0] old;
      input [31:0] d;
      input [3:0]  strb;
      input [15:0] msk;
      reg   [15:0] lane;
      begin
         lane = {{8{strb[1]}}, {8{strb[0]}}} & msk;
         merge = (old & ~lane) | (d[15:0] & lane);
      end
   endfunction

   function [15:0] rd_mux;
      input [7:0] idx;
      begin
         case (idx)
            `BCR_IDX_ACTIVE: rd_mux = active_reg;
            `BCR_IDX_SLEEP:  rd_mux = sleep_reg;
            `BCR_IDX_CMP:    rd_mux = cmp_reg;
            `BCR_IDX_C1CTL:  rd_mux = c1ctl_reg;
            `BCR_IDX_C1SEQ:  rd_mux = c1seq_reg;
            `BCR_IDX_KEY:    rd_mux = {15'h0000, unlock_reg};
            `BCR_IDX_IRQST:  rd_mux = {14'h0000, irqst_reg};
            `BCR_IDX_IRQMSK: rd_mux = {14'h0000, irqmsk_reg};
            `BCR_IDX_STATUS: rd_mux = {13'h0000, conv1_enable, flt_reg, low_reg};
            default:         rd_mux = 16'h0000;
         endcase
      end
   endfunction

   function hit;
      input [7:0] idx;
      begin
         hit = (idx >= `BCR_IDX_ACTIVE && idx <= `BCR_IDX_C1SEQ) ||
               (idx >= `BCR_IDX_KEY && idx <= `BCR_IDX_STATUS);
      end
   endfunction

   // Pin inputs: three stages, accept a level once the last two agree
   always @(posedge aclk) begin
      if (!aresetn) begin
         low_sync_reg <= 3'h0;
         flt_sync_reg <= 3'h0;
         low_reg      <= 1'b0;
         flt_reg      <= 1'b0;
      end else begin
         low_sync_reg <= {low_sync_reg[1:0], supply_low};
         flt_sync_reg <= {flt_sync_reg[1:0], conv1_fault};
         if (low_sync_reg[2] == low_sync_reg[1])
            low_reg <= low_sync_reg[1];
         if (flt_sync_reg[2] == flt_sync_reg[1])
            flt_reg <= flt_sync_reg[1];
      end
   end

   // AXI write: address and data taken in either order, response after both
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg   <= 1'b0;
         w_hold_reg    <= 1'b0;
         awaddr_reg    <= {AW{1'b0}};
         wdata_reg     <= 32'h0000_0000;
         wstrb_reg     <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end else begin
         s_axi_awready <= !aw_hold_reg && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_hold_reg && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg   <= 1'b1;
            awaddr_reg    <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg   <= 1'b1;
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= hit(widx) ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI read: one cycle after arready handshake
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {16'h0000, rd_mux(ridx)};
            s_axi_rresp  <= hit(ridx) ? 2'h0 : 2'h2;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Register file; the state machine reset reloads the reset defaults like power-on
   always @(posedge aclk) begin
      if (!aresetn || sm_reset) begin
         active_reg <= `BCR_RST_ACTIVE;
         sleep_reg  <= `BCR_RST_SLEEP;
         cmp_reg    <= `BCR_RST_CMP;
         c1ctl_reg  <= `BCR_RST_C1CTL;
         c1seq_reg  <= `BCR_RST_C1SEQ;
         unlock_reg <= 1'b0;
         irqmsk_reg <= 2'h0;
      end else if (wr_go) begin
         case (widx)
            `BCR_IDX_ACTIVE: active_reg <= merge(active_reg, wdata_reg, wstrb_reg, `BCR_MSK_ACTIVE);
            `BCR_IDX_SLEEP:  sleep_reg  <= merge(sleep_reg, wdata_reg, wstrb_reg, `BCR_MSK_SLEEP);
            `BCR_IDX_CMP:    cmp_reg    <= merge(cmp_reg, wdata_reg, wstrb_reg,
                                                 unlock_reg ? `BCR_MSK_CMP : (`BCR_MSK_CMP & ~`BCR_MSK_THR));
            `BCR_IDX_C1CTL: begin
               // Unused capacitor code and codes above the maximum are refused
               c1ctl_reg <= merge(c1ctl_reg, wdata_reg, wstrb_reg, `BCR_MSK_C1CTL
                                  & ((wdata_reg[`BCR_F_CAP] == `BCR_CAP_UNUSED) ? 16'h3FFF : 16'hFFFF)
                                  & ((wdata_reg[`BCR_F_VSEL] > `BCR_VSEL_MAX) ? 16'hFF80 : 16'hFFFF));
            end
            `BCR_IDX_C1SEQ:  c1seq_reg  <= merge(c1seq_reg, wdata_reg, wstrb_reg, `BCR_MSK_C1SEQ);
            `BCR_IDX_KEY:    unlock_reg <= (wdata_reg[15:0] == `BCR_KEY_UNLOCK);
            `BCR_IDX_IRQMSK: irqmsk_reg <= wdata_reg[1:0];
            default:         unlock_reg <= unlock_reg;
         endcase
      end
   end

   // Sticky interrupt status; a new event wins over a write-one clear
   always @(posedge aclk) begin
      if (!aresetn) begin
         irqst_reg <= 2'h0;
         irq       <= 1'b0;
      end else begin
         irqst_reg <= (irqst_reg & ~((wr_go && widx == `BCR_IDX_IRQST) ? wdata_reg[1:0] : 2'h0))
                      | {flt_rise, low_rise};
         irq       <= |(irqst_reg & irqmsk_reg);
      end
   end

   // Converter and comparator outputs, plus slot sequencing
   always @(posedge aclk) begin
      if (!aresetn || sm_reset) begin
         conv1_active_select        <= 1'b1;
         sleep_ldo_select           <= 4'h0;
         supply_check_hibernate_use <= 1'b0;
         supply_turnoff_threshold   <= 3'h2;
         supply_turnon_threshold    <= 3'h5;
         conv1_output_cap_range     <= 2'h0;
         conv1_overvoltage_on       <= 1'b1;
         conv1_discharge_en         <= 1'b1;
         conv1_voltage_code         <= 7'h0E;
         conv1_enable               <= 1'b0;
         conv1_shutdown_req         <= 1'b0;
         system_shutdown_req        <= 1'b0;
      end else begin
         conv1_active_select        <= active_reg[0];
         sleep_ldo_select           <= {sleep_reg[`BCR_B_SLP6], sleep_reg[`BCR_B_SLP4],
                                        sleep_reg[`BCR_B_SLP3], sleep_reg[`BCR_B_SLP1]};
         supply_check_hibernate_use <= cmp_reg[`BCR_B_CMP_HIB];
         // Analog maps codes linearly, 2.9V plus 100mV per step
         supply_turnoff_threshold   <= cmp_reg[`BCR_F_OFFTHR];
         supply_turnon_threshold    <= cmp_reg[`BCR_F_ONTHR];
         conv1_output_cap_range     <= c1ctl_reg[`BCR_F_CAP];
         conv1_overvoltage_on       <= !c1ctl_reg[`BCR_B_OVPOFF];
         conv1_discharge_en         <= !c1ctl_reg[`BCR_B_FLOAT] && !conv1_enable;
         conv1_voltage_code         <= c1ctl_reg[`BCR_F_VSEL];
         // Slots are walked in ascending order by the sequencer outside; we act on our own slot
         if (seq_startup && en_slot != `BCR_SLOT_NONE && en_slot != `BCR_SLOT_ACTIVE && seq_slot == en_slot)
            conv1_enable <= 1'b1;
         else if (enter_active && en_slot == `BCR_SLOT_ACTIVE)
            conv1_enable <= 1'b1;
         else if (seq_shutdown && sd_slot != `BCR_SLOT_NONE && sd_slot != `BCR_SLOT_ACTIVE
                  && seq_slot == sd_slot)
            conv1_enable <= 1'b0;
         else if (enter_off && (sd_slot == `BCR_SLOT_NONE || sd_slot == `BCR_SLOT_ACTIVE))
            conv1_enable <= 1'b0;
         else if (flt_rise && fact == `BCR_FACT_CONV)
            conv1_enable <= 1'b0;
         conv1_shutdown_req  <= flt_rise && fact == `BCR_FACT_CONV;
         system_shutdown_req <= (flt_rise && fact != `BCR_FACT_IGNORE && fact != `BCR_FACT_CONV)
                                || (low_rise && cmp_reg[`BCR_B_CMP_ACT]);
      end
   end
endmodule

// ===== test/bcr_regs_sva.sv
// Assertions on the converter register bank, watching only its ports.
// Assumes one clock and the synchronous active-low reset of the bank.
module bcr_regs_sva (
   input wire       aclk,
   input wire       aresetn,
   input wire       sm_reset,
   input wire       supply_low,
   input wire       conv1_fault,
   input wire       seq_startup,
   input wire       seq_shutdown,
   input wire       enter_active,
   input wire       enter_off,
   input wire [2:0] supply_turnoff_threshold,
   input wire [2:0] supply_turnon_threshold,
   input wire [1:0] conv1_output_cap_range,
   input wire       conv1_discharge_en,
   input wire [6:0] conv1_voltage_code,
   input wire       conv1_enable,
   input wire       conv1_shutdown_req,
   input wire       system_shutdown_req,
   input wire       irq
);
   wire       start_ev = seq_startup | enter_active;
   wire       stop_ev  = seq_shutdown | enter_off | sm_reset | conv1_shutdown_req | system_shutdown_req;
   reg  [4:0] quiet_cnt;
   // Saturates so a long quiet stretch never wraps back into the window
   always @(posedge aclk) begin
      if (!aresetn || supply_low || conv1_fault)
         quiet_cnt <= 5'h00;
      else if (quiet_cnt != 5'h1F)
         quiet_cnt <= quiet_cnt + 5'h01;
   end
   default clocking dcb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence sm_pulse;
      $rose(sm_reset);
   endsequence
   sequence held_on;
      conv1_enable [*3];
   endsequence
   thr_reload_a:
      assert property (sm_pulse |-> ##2 (supply_turnoff_threshold == 3'h2 && supply_turnon_threshold == 3'h5))
      else $error("thresholds not reloaded");
   mask_reload_a:
      assert property (sm_pulse |-> ##[1:4] !irq) else $error("irq survives state reset");
   cap_unused_a:
      assert property (conv1_output_cap_range != 2'h2) else $error("unused cap code taken");
   vcode_max_a:
      assert property (conv1_voltage_code <= 7'h66) else $error("voltage code above maximum");
   no_discharge_a:
      assert property (held_on |-> !conv1_discharge_en) else $error("discharge while enabled");
   start_cause_a:
      assert property ($rose(conv1_enable) |-> $past(start_ev) || $past(start_ev, 2) || $past(start_ev, 3))
      else $error("enable without start event");
   stop_cause_a:
      assert property ($fell(conv1_enable) |-> stop_ev || $past(stop_ev) || $past(stop_ev, 2) || $past(stop_ev, 3))
      else $error("enable dropped without stop event");
   conv_only_a:
      assert property (conv1_shutdown_req |-> !system_shutdown_req ##[0:2] !conv1_enable)
      else $error("converter shutdown misbehaves");
   sys_cause_a:
      assert property (system_shutdown_req |-> quiet_cnt < 5'h10) else $error("system shutdown without cause");
endmodule
bind bcr_regs bcr_regs_sva i_bcr_regs_sva (.*);

// ===== test/test_buck_converter_control_regs.sv
// Self-checking bench for the converter register bank over AXI4-Lite.
// Assumes the bank decodes byte address = register index times four.
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t mismatch %h exp %h", $time, a, b); end end
module test_buck_converter_control_regs;
   timeunit 1ns;
   timeprecision 100ps;
   logic        aclk = 1'h0, aresetn = 1'h0, sm_reset = 1'h0, supply_low = 1'h0, conv1_fault = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rval;
   logic [3:0]  s_axi_wstrb = 4'h3, seq_slot = 4'h0, sleep_ldo_select;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic        s_axi_rready = 1'h0, seq_startup = 1'h0, seq_shutdown = 1'h0, enter_active = 1'h0, enter_off = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv1_active_select;
   logic        supply_check_hibernate_use, conv1_overvoltage_on, conv1_discharge_en, conv1_enable, irq;
   logic        conv1_shutdown_req, system_shutdown_req;
   logic [1:0]  s_axi_bresp, s_axi_rresp, conv1_output_cap_range, rresp_v;
   logic [2:0]  supply_turnoff_threshold, supply_turnon_threshold;
   logic [6:0]  conv1_voltage_code;
   integer      fails = 0, checks_done = 0;
   bcr_regs i_bcr_regs (.*);
   always #12.5 aclk = ~aclk;
   task automatic final_report;
      if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic tmo;
      fails++;
      $display("[ERR] %0t wait ran out", $time);
      final_report;
   endtask
   // Idle edge at the end keeps back-to-back calls from driving a strobe twice in one step
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      integer n;
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'h0;
      if (n == 40) tmo;
      @(posedge aclk);
   endtask
   task automatic rd_reg(input logic [11:0] a);
      integer n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) break;
      end
      rval = s_axi_rdata;
      rresp_v = s_axi_rresp;
      s_axi_rready <= 1'h0;
      if (n == 40) tmo;
      @(posedge aclk);
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: pick = irq;
         1: pick = conv1_enable;
         3: pick = conv1_shutdown_req;
         default: pick = system_shutdown_req;
      endcase
   endfunction
   task automatic wait_for(input int s, input logic v);
      integer n;
      checks_done++;
      for (n = 0; n < 30 && pick(s) !== v; n++) @(posedge aclk);
      if (n == 30) tmo;
   endtask
   task automatic go_active;
      enter_active <= 1'h1;
      @(posedge aclk);
      enter_active <= 1'h0;
      wait_for(1, 1'h1);
   endtask
   task automatic t_reset;
      rd_reg(12'h2C4);
      `CHK(rval, 32'h1);
      rd_reg(12'h2CC);
      `CHK(rval, 32'h25);
      rd_reg(12'h2D4);
      `CHK(rval, 32'h400);
      rd_reg(12'h3F0);
      `CHK({rresp_v, rval}, {2'h2, 32'h0});
      `CHK({conv1_active_select, conv1_overvoltage_on, conv1_discharge_en, conv1_voltage_code}, 10'h38E);
   endtask
   task automatic t_key;
      wr(12'h2CC, 16'h0000);
      rd_reg(12'h2CC);
      `CHK(rval, 32'h25);
      wr(12'h300, 16'h0097);
      wr(12'h2CC, 16'h5077);
      rd_reg(12'h2CC);
      `CHK(rval, 32'h5077);
      `CHK({supply_turnoff_threshold, supply_turnon_threshold, supply_check_hibernate_use}, 7'h7F);
      wr(12'h300, 16'h0000);
      wr(12'h2CC, 16'h0000);
      rd_reg(12'h2CC);
      `CHK(rval, 32'h77);
   endtask
   task automatic t_fields;
      wr(12'h2C8, 16'h002D);
      `CHK(sleep_ldo_select, 4'hF);
      wr(12'h2D0, 16'h8066);
      rd_reg(12'h2D0);
      `CHK(rval, 32'h66);
      wr(12'h2D0, 16'h0067);
      rd_reg(12'h2D0);
      `CHK({rval, conv1_discharge_en}, 33'h0CD);
      wr(12'h2D0, 16'hCC62);
      rd_reg(12'h2D0);
      `CHK({conv1_output_cap_range, conv1_overvoltage_on, conv1_discharge_en, conv1_voltage_code}, 11'h662);
   endtask
   task automatic t_seq;
      wr(12'h308, 16'h0003);
      wr(12'h2D4, 16'h7C00);
      go_active;
      enter_off <= 1'h1;
      @(posedge aclk);
      enter_off <= 1'h0;
      wait_for(1, 1'h0);
      go_active;
      conv1_fault <= 1'h1;
      wait_for(3, 1'h1);
      wait_for(0, 1'h1);
      wait_for(1, 1'h0);
      conv1_fault <= 1'h0;
      wr(12'h304, 16'h0002);
      wait_for(0, 1'h0);
   endtask
   // Start in slot 2, stop in slot 3, fault action ignore
   task automatic t_slots;
      wr(12'h2D4, 16'h08C0);
      seq_slot <= 4'h2;
      seq_startup <= 1'h1;
      wait_for(1, 1'h1);
      seq_startup <= 1'h0;
      rd_reg(12'h30C);
      `CHK(rval, 32'h4);
      seq_slot <= 4'h3;
      seq_shutdown <= 1'h1;
      wait_for(1, 1'h0);
      seq_shutdown <= 1'h0;
      seq_slot <= 4'h0;
   endtask
   task automatic t_supply;
      wr(12'h2CC, 16'h4000);
      supply_low <= 1'h1;
      wait_for(2, 1'h1);
      wait_for(0, 1'h1);
      wr(12'h308, 16'h0000);
      wait_for(0, 1'h0);
      supply_low <= 1'h0;
      wr(12'h304, 16'h0001);
      rd_reg(12'h304);
      `CHK(rval, 32'h0);
   endtask
   task automatic t_smreset;
      sm_reset <= 1'h1;
      @(posedge aclk);
      sm_reset <= 1'h0;
      rd_reg(12'h2CC);
      `CHK(rval, 32'h25);
      rd_reg(12'h2D0);
      `CHK(rval, 32'hE);
      rd_reg(12'h2C8);
      `CHK(rval, 32'h0);
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_reset;
      t_key;
      t_fields;
      t_seq;
      t_slots;
      t_supply;
      t_smreset;
      final_report;
   end
endmodule
